// ===== hw/cmsf_consts.svh
`ifndef CMSF_CONSTS_SVH
`define CMSF_CONSTS_SVH
// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define CMSF_OFS_ABORT 12'h000
`define CMSF_OFS_RX 12'h004
`define CMSF_OFS_REMOTE 12'h008
`define CMSF_OFS_IRQ_STAT 12'h00C
`define CMSF_OFS_IRQ_CLR 12'h010
`define CMSF_OFS_IRQ_EN 12'h014
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CMSF_FLAG_RST 16'h0000
`define CMSF_IRQ_EN_RST 16'h0000
`define CMSF_RDATA_RST 32'h0000_0000
// ------------------------------------------------------------
// field layouts; flag masks in mailbox order (bit n = mailbox n), irq bits by source
// ------------------------------------------------------------
`define CMSF_ABORT_KEEP 16'hFFFE
`define CMSF_ALL_KEEP 16'hFFFF
`define CMSF_IRQ_KEEP 16'h0007
`define CMSF_IRQ_ABORT 0
`define CMSF_IRQ_RX 1
`define CMSF_IRQ_REMOTE 2
// ------------------------------------------------------------
// bank indices
// ------------------------------------------------------------
`define CMSF_NUM_BANKS 4
`define CMSF_BANK_ABORT 0
`define CMSF_BANK_RX 1
`define CMSF_BANK_REMOTE 2
`define CMSF_BANK_IRQ 3
`endif

// ===== hw/cmsf_pkg.sv
package cmsf_pkg;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cmsf_apb_req_t;
  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cmsf_apb_rsp_t;
  // bus phase, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_ACCESS = 2'b10
  } cmsf_phase_t;
  // state of one flag bank
  typedef struct packed {
    logic [15:0] flags;
  } cmsf_bank_st_t;
  // state of the top module
  typedef struct packed {
    cmsf_phase_t phase;
    cmsf_apb_rsp_t rsp;
    logic [15:0] irq_en;
    logic irq;
    logic rx_irq;
    logic rem_irq;
    logic [15:0] tx_clear;
  } cmsf_top_st_t;
endpackage

// ===== hw/cmsf_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmsf_consts.svh"
// sticky flag bank: hardware sets, software clears by writing 1
module cmsf_flag_bank (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [15:0] keep_i,
  input wire logic [15:0] set_i,
  input wire logic [15:0] clr_i,
  output logic [15:0] flags_o,
  output logic [15:0] flags_nx_o
);
  cmsf_pkg::cmsf_bank_st_t st_reg; // flag storage
  cmsf_pkg::cmsf_bank_st_t st_next; // value after the next edge

  // ------------------------------------------------------------
  // next value
  // ------------------------------------------------------------
  // set is or-ed last so a same-cycle event survives the clear
  always_comb begin
    st_next = st_reg;
    st_next.flags = ((st_reg.flags & ~clr_i) | set_i) & keep_i;
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // frozen while the clock enable is low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg.flags <= `CMSF_FLAG_RST; // R11
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign flags_o = st_reg.flags;
  // lets the parent register summaries in step with the flags
  assign flags_nx_o = clk_en_i ? st_next.flags : st_reg.flags;
endmodule // cmsf_flag_bank
`default_nettype wire

// ===== hw/cmsf_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmsf_consts.svh"
// Notes on behaviour
// [R1] abort flag per mailbox 1..15, set on cancel
// [R2] abort bits 15..9 mb7..1, 7..0 mb15..8
// [R3] abort bit 8 reads 0, write 0
// [R4] abort flag held until written with 1
// [R5] receive flag per mailbox 0..15
// [R6] receive flag set on data or remote
// [R7] receive/remote bits 15..8 mb7..0, 7..0 mb15..8
// [R8] remote flag set on remote frame, W1C
// [R9] remote frame sets receive flag same cycle
// [R10] remote flag never set without receive flag
// [R11] all flags zero after reset
// [R12] transmit wait cleared on send or cancel
// [R13] receive irq flag clears when receive flags empty
// [R14] remote irq flag clears when remote flags empty
// [R15] hardware set wins over software clear
module cmsf_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire cmsf_pkg::cmsf_apb_req_t apb_req_i,
  input wire logic [15:0] abort_done_i,
  input wire logic [15:0] tx_done_i,
  input wire logic [15:0] rx_done_i,
  input wire logic [15:0] rx_remote_i,
  input wire logic [15:0] mailbox_irq_mask_i,
  output cmsf_pkg::cmsf_apb_rsp_t apb_rsp_o,
  output logic irq_o,
  output logic receive_message_irq_flag_o,
  output logic remote_frame_irq_flag_o,
  output logic [15:0] transmit_wait_clear_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // mailbox order to register order; the swap is its own inverse
  function automatic logic [15:0] mb_swap(input logic [15:0] v);
    mb_swap = {v[7:0], v[15:8]};
  endfunction

  // one-hot register hit, zero for an unmapped address
  function automatic logic [5:0] reg_hit(input logic [11:0] a);
    if (a == `CMSF_OFS_ABORT) begin
      reg_hit = 6'h01;
    end else if (a == `CMSF_OFS_RX) begin
      reg_hit = 6'h02;
    end else if (a == `CMSF_OFS_REMOTE) begin
      reg_hit = 6'h04;
    end else if (a == `CMSF_OFS_IRQ_STAT) begin
      reg_hit = 6'h08;
    end else if (a == `CMSF_OFS_IRQ_CLR) begin
      reg_hit = 6'h10;
    end else if (a == `CMSF_OFS_IRQ_EN) begin
      reg_hit = 6'h20;
    end else begin
      reg_hit = 6'h00;
    end
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  cmsf_pkg::cmsf_top_st_t st_reg; // all top state
  cmsf_pkg::cmsf_top_st_t st_next; // its next value
  logic [15:0] set_v [`CMSF_NUM_BANKS]; // per bank set events
  logic [15:0] clr_v [`CMSF_NUM_BANKS]; // per bank w1c strobes
  logic [15:0] keep_v [`CMSF_NUM_BANKS]; // implemented bits
  logic [15:0] flg [`CMSF_NUM_BANKS]; // current flags
  logic [15:0] flg_nx [`CMSF_NUM_BANKS]; // flags after the edge
  logic [5:0] hit; // decoded address
  logic acc; // access edge of a transfer
  logic [15:0] abort_set; // abort completions, mailbox 1..15
  logic [15:0] rem_set; // remote frame completions
  logic [15:0] wdat; // low write half

  assign hit = reg_hit(apb_req_i.paddr);
  assign wdat = apb_req_i.pwdata[15:0];
  // the request is taken only at the edge where pready stands high
  assign acc = (st_reg.phase == cmsf_pkg::PH_ACCESS) && apb_req_i.psel && apb_req_i.penable;
  // mailbox 0 cannot transmit so it has no abort flag
  assign abort_set = abort_done_i & `CMSF_ABORT_KEEP; // R1
  // a remote frame only counts as a completed reception
  assign rem_set = rx_done_i & rx_remote_i; // R10

  // ------------------------------------------------------------
  // set and clear vectors of the four banks
  // ------------------------------------------------------------
  always_comb begin
    set_v[`CMSF_BANK_ABORT] = abort_set; // R1
    // data and remote frames both complete a reception
    set_v[`CMSF_BANK_RX] = rx_done_i; // R5 R6 R9
    set_v[`CMSF_BANK_REMOTE] = rem_set; // R8 R9
    set_v[`CMSF_BANK_IRQ] = 16'h0000;
    set_v[`CMSF_BANK_IRQ][`CMSF_IRQ_ABORT] = |abort_set;
    set_v[`CMSF_BANK_IRQ][`CMSF_IRQ_RX] = |rx_done_i;
    set_v[`CMSF_BANK_IRQ][`CMSF_IRQ_REMOTE] = |rem_set;
    keep_v[`CMSF_BANK_ABORT] = `CMSF_ABORT_KEEP; // R3
    keep_v[`CMSF_BANK_RX] = `CMSF_ALL_KEEP;
    keep_v[`CMSF_BANK_REMOTE] = `CMSF_ALL_KEEP;
    keep_v[`CMSF_BANK_IRQ] = `CMSF_IRQ_KEEP;
    // writing 1 clears, 0 leaves alone; swap brings bits to mailbox order
    clr_v[`CMSF_BANK_ABORT] = (acc && apb_req_i.pwrite && hit[0]) ? mb_swap(wdat) : 16'h0000; // R2 R4
    clr_v[`CMSF_BANK_RX] = (acc && apb_req_i.pwrite && hit[1]) ? mb_swap(wdat) : 16'h0000; // R6 R7
    clr_v[`CMSF_BANK_REMOTE] = (acc && apb_req_i.pwrite && hit[2]) ? mb_swap(wdat) : 16'h0000; // R7 R8
    clr_v[`CMSF_BANK_IRQ] = (acc && apb_req_i.pwrite && hit[4]) ? wdat : 16'h0000;
  end

  // ------------------------------------------------------------
  // flag banks
  // ------------------------------------------------------------
  // set beats clear inside each bank
  for (genvar b = 0; b < `CMSF_NUM_BANKS; b++) begin : g_bank // R15
    cmsf_flag_bank u_bank (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .keep_i(keep_v[b]),
      .set_i(set_v[b]),
      .clr_i(clr_v[b]),
      .flags_o(flg[b]),
      .flags_nx_o(flg_nx[b])
    );
  end

  // ------------------------------------------------------------
  // bus phase, read mux and summaries
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      cmsf_pkg::PH_IDLE: begin
        st_next.rsp.pready = 1'b0;
        st_next.rsp.pslverr = 1'b0;
        // setup cycle: answer is ready at the first access edge
        if (apb_req_i.psel && !apb_req_i.penable) begin
          st_next.phase = cmsf_pkg::PH_ACCESS;
          st_next.rsp.pready = 1'b1;
          st_next.rsp.pslverr = (hit == 6'h00);
          st_next.rsp.prdata = `CMSF_RDATA_RST;
          // reserved and unmapped bits read as zero
          if (!apb_req_i.pwrite) begin
            if (hit[0]) begin
              st_next.rsp.prdata[15:0] = mb_swap(flg[`CMSF_BANK_ABORT]); // R2 R3
            end else if (hit[1]) begin
              st_next.rsp.prdata[15:0] = mb_swap(flg[`CMSF_BANK_RX]); // R7
            end else if (hit[2]) begin
              st_next.rsp.prdata[15:0] = mb_swap(flg[`CMSF_BANK_REMOTE]); // R7
            end else if (hit[3]) begin
              st_next.rsp.prdata[15:0] = flg[`CMSF_BANK_IRQ];
            end else if (hit[5]) begin
              st_next.rsp.prdata[15:0] = st_reg.irq_en;
            end
          end
        end
      end
      cmsf_pkg::PH_ACCESS: begin
        // transfer ends here; the write strobes fire this edge
        if (acc) begin
          st_next.phase = cmsf_pkg::PH_IDLE;
          st_next.rsp.pready = 1'b0;
          st_next.rsp.pslverr = 1'b0;
          if (apb_req_i.pwrite && hit[5]) begin
            st_next.irq_en = wdat & `CMSF_IRQ_KEEP;
          end
        end
      end
      default: begin
        st_next.phase = cmsf_pkg::PH_IDLE;
      end
    endcase
    // pulse for the transmit wait register beside this block
    st_next.tx_clear = (tx_done_i | abort_done_i) & `CMSF_ABORT_KEEP; // R12
    // summary irq follows the flags after this edge
    st_next.irq = |(flg_nx[`CMSF_BANK_IRQ] & st_next.irq_en);
    // set by unmasked receptions, dropped only once all flags are gone
    st_next.rx_irq = (st_reg.rx_irq | (|(rx_done_i & ~mailbox_irq_mask_i)))
                     & (|flg_nx[`CMSF_BANK_RX]); // R13
    st_next.rem_irq = (st_reg.rem_irq | (|(rem_set & ~mailbox_irq_mask_i)))
                      & (|flg_nx[`CMSF_BANK_REMOTE]); // R14
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // synchronous reset; clock enable freezes everything
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg.phase <= cmsf_pkg::PH_IDLE;
      st_reg.rsp.prdata <= `CMSF_RDATA_RST;
      st_reg.rsp.pready <= 1'b0;
      st_reg.rsp.pslverr <= 1'b0;
      st_reg.irq_en <= `CMSF_IRQ_EN_RST;
      st_reg.irq <= 1'b0;
      st_reg.rx_irq <= 1'b0;
      st_reg.rem_irq <= 1'b0;
      st_reg.tx_clear <= `CMSF_FLAG_RST;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign apb_rsp_o = st_reg.rsp;
  assign irq_o = st_reg.irq;
  assign receive_message_irq_flag_o = st_reg.rx_irq;
  assign remote_frame_irq_flag_o = st_reg.rem_irq;
  assign transmit_wait_clear_o = st_reg.tx_clear;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // a cancel completion with the clock enable high always lands, even against a clear
  a_abort_set_lands: assert property ( // R1 R15
    (clk_en_i && abort_set != 16'h0000) |=>
      ((flg[`CMSF_BANK_ABORT] & $past(abort_set)) == $past(abort_set)))
    else $error("abort flag not set by cancel completion");

  // reserved position never holds a flag
  a_abort_rsvd_zero: assert property ( // R3
    flg[`CMSF_BANK_ABORT][0] == 1'b0 && !(apb_rsp_o.pready && apb_rsp_o.prdata[8]
      && $past(hit[0]) && !$past(apb_req_i.pwrite)))
    else $error("reserved abort bit seen as one");

  // abort read shows the swapped layout
  a_abort_read_map: assert property ( // R2
    ($rose(apb_rsp_o.pready) && $past(hit[0]) && !$past(apb_req_i.pwrite)) |->
      (apb_rsp_o.prdata[15:0] == {$past(flg[0][7:0]), $past(flg[0][15:8])}))
    else $error("abort read data in wrong bit order");

  // without a write access no abort flag falls
  a_abort_hold: assert property ( // R4
    !(acc && apb_req_i.pwrite) |=>
      ((flg[`CMSF_BANK_ABORT] & $past(flg[`CMSF_BANK_ABORT])) == $past(flg[`CMSF_BANK_ABORT])))
    else $error("abort flag dropped without a write");

  // every reception, data or remote, with the clock enable high sets its flag
  a_rx_set_lands: assert property ( // R5 R6 R15
    (clk_en_i && rx_done_i != 16'h0000) |=>
      ((flg[`CMSF_BANK_RX] & $past(rx_done_i)) == $past(rx_done_i)))
    else $error("receive flag not set by reception");

  // receive read shows the swapped layout
  a_rx_read_map: assert property ( // R7
    ($rose(apb_rsp_o.pready) && $past(hit[1]) && !$past(apb_req_i.pwrite)) |->
      (apb_rsp_o.prdata[15:0] == {$past(flg[1][7:0]), $past(flg[1][15:8])}))
    else $error("receive read data in wrong bit order");

  // a new remote flag has a remote reception behind it
  a_rem_has_cause: assert property ( // R8 R10
    ((flg[`CMSF_BANK_REMOTE] & ~$past(flg[`CMSF_BANK_REMOTE])) & ~$past(rem_set)) == 16'h0000)
    else $error("remote flag rose without remote frame");

  // a remote frame raises both flags together
  a_rem_pairs_rx: assert property ( // R9
    (clk_en_i && rem_set != 16'h0000) |=>
      ((flg[`CMSF_BANK_RX] & flg[`CMSF_BANK_REMOTE] & $past(rem_set)) == $past(rem_set)))
    else $error("remote frame did not set both flags");

  // first cycle after reset shows empty abort, receive and remote flags
  a_reset_clean: assert property ( // R11
    $past(rst_i) |-> (flg[0] == 16'h0000 && flg[1] == 16'h0000 && flg[2] == 16'h0000))
    else $error("flags not cleared by reset");

  // transmit wait clear pulse follows send or cancel by one cycle
  a_txwait_clear: assert property ( // R12
    clk_en_i |=> (transmit_wait_clear_o == (($past(tx_done_i) | $past(abort_done_i)) & 16'hFFFE)))
    else $error("transmit wait clear pulse wrong");

  // receive irq flag cannot outlive the receive flags
  a_rxirq_empty: assert property ( // R13
    (flg[`CMSF_BANK_RX] == 16'h0000) |-> !receive_message_irq_flag_o)
    else $error("receive irq flag set with no receive flag");

  // remote irq flag cannot outlive the remote flags
  a_remirq_empty: assert property ( // R14
    (flg[`CMSF_BANK_REMOTE] == 16'h0000) |-> !remote_frame_irq_flag_o)
    else $error("remote irq flag set with no remote flag");

  // an unmasked reception raises the receive irq flag next cycle
  a_rxirq_sets: assert property ( // R13
    (clk_en_i && (rx_done_i & ~mailbox_irq_mask_i) != 16'h0000) |=> receive_message_irq_flag_o)
    else $error("receive irq flag missed an unmasked reception");

  // an unmasked remote frame raises the remote irq flag next cycle
  a_remirq_sets: assert property ( // R14
    (clk_en_i && (rem_set & ~mailbox_irq_mask_i) != 16'h0000) |=> remote_frame_irq_flag_o)
    else $error("remote irq flag missed an unmasked remote frame");

  // masked or absent receptions never raise the receive irq flag
  a_rxirq_no_cause: assert property ( // R13
    (!receive_message_irq_flag_o && (rx_done_i & ~mailbox_irq_mask_i) == 16'h0000) |=>
      !receive_message_irq_flag_o)
    else $error("receive irq flag rose without cause");

  // masked or absent remote frames never raise the remote irq flag
  a_remirq_no_cause: assert property ( // R14
    (!remote_frame_irq_flag_o && (rem_set & ~mailbox_irq_mask_i) == 16'h0000) |=>
      !remote_frame_irq_flag_o)
    else $error("remote irq flag rose without cause");

  // ------------------------------------------------------------
  // bus and interrupt output checks
  // ------------------------------------------------------------
  // a setup cycle is answered at the very next edge, no wait states
  a_pready_after_setup: assert property (
    (clk_en_i && st_reg.phase == cmsf_pkg::PH_IDLE && apb_req_i.psel && !apb_req_i.penable) |=>
      apb_rsp_o.pready)
    else $error("setup cycle not answered with pready");

  // pready stands for the access cycle only
  a_pready_pulse: assert property (
    (clk_en_i && acc) |=> !apb_rsp_o.pready)
    else $error("pready held past the access edge");

  // unmapped address answers with an error and zero data
  a_unmapped_err: assert property (
    (clk_en_i && st_reg.phase == cmsf_pkg::PH_IDLE && apb_req_i.psel && !apb_req_i.penable
      && hit == 6'h00) |=> (apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  // registers are 16 bits wide, upper read half stays zero
  a_upper_zero: assert property (
    apb_rsp_o.prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // interrupt line high exactly while an enabled status bit is set
  a_irq_level: assert property (
    irq_o == (|(flg[`CMSF_BANK_IRQ] & st_reg.irq_en)))
    else $error("interrupt line disagrees with status and enable");

  // status is read-only: a write there clears nothing
  a_irq_stat_ro: assert property (
    (acc && apb_req_i.pwrite && hit[3]) |=>
      ((flg[`CMSF_BANK_IRQ] & $past(flg[`CMSF_BANK_IRQ])) == $past(flg[`CMSF_BANK_IRQ])))
    else $error("write to irq status cleared a bit");

  // enable write keeps only the three implemented bits
  a_irq_en_write: assert property (
    (clk_en_i && acc && apb_req_i.pwrite && hit[5]) |=> (st_reg.irq_en == ($past(wdat) & `CMSF_IRQ_KEEP)))
    else $error("irq enable write not taken");

  // clock enable low freezes every flag and the interrupt line
  a_freeze_flags: assert property (
    !clk_en_i |=> (flg[0] == $past(flg[0]) && flg[1] == $past(flg[1]) && flg[2] == $past(flg[2])
      && flg[3] == $past(flg[3]) && irq_o == $past(irq_o)))
    else $error("state moved while clock enable was low");
endmodule // cmsf_top
`default_nettype wire

// ===== tb/cmsf_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// protocol engine stand-in: one-cycle completion events
// ------------------------------------------------------------
module cmsf_engine_model (
  input wire logic sys_clk_i,
  output logic [15:0] abort_done_o,
  output logic [15:0] tx_done_o,
  output logic [15:0] rx_done_o,
  output logic [15:0] rx_remote_o
);
  // idle levels; the qualifier is never left quiet
  initial begin
    abort_done_o = 16'h0000;
    tx_done_o = 16'h0000;
    rx_done_o = 16'h0000;
    rx_remote_o = 16'hFFFF;
  end
  // one event cycle, launched after the next edge
  task automatic fire(input logic [15:0] ab, input logic [15:0] tx, input logic [15:0] rx, input logic [15:0] rm);
    @(posedge sys_clk_i);
    abort_done_o <= ab;
    tx_done_o <= tx;
    rx_done_o <= rx;
    rx_remote_o <= rm;
    @(posedge sys_clk_i);
    abort_done_o <= 16'h0000;
    tx_done_o <= 16'h0000;
    rx_done_o <= 16'h0000;
    // qualifier is meaningless now: show the inverse, not a stale copy
    rx_remote_o <= ~rm;
  endtask
endmodule // cmsf_engine_model
`default_nettype wire

// ===== tb/cmsf_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cmsf_consts.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module cmsf_top_tb;
  // ------------------------------------------------------------
  // clock, reset, bus and event wiring
  // ------------------------------------------------------------
  logic sys_clk_i;
  logic rst_i;
  logic [15:0] mask;
  cmsf_pkg::cmsf_apb_req_t req;
  cmsf_pkg::cmsf_apb_rsp_t rsp;
  logic [15:0] ab, tx, rx, rm, twc;
  logic irq, rx_irq, rem_irq;
  logic [31:0] d;
  logic e;
  logic ce; // clock enable, dropped once to check freezing
  int error_cnt = 0;
  int check_count = 0;
  cmsf_engine_model eng (.sys_clk_i(sys_clk_i), .abort_done_o(ab), .tx_done_o(tx), .rx_done_o(rx),
    .rx_remote_o(rm));
  // clock enable driven so the freeze path is exercised
  cmsf_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(ce), .apb_req_i(req), .abort_done_i(ab),
    .tx_done_i(tx), .rx_done_i(rx), .rx_remote_i(rm), .mailbox_irq_mask_i(mask), .apb_rsp_o(rsp),
    .irq_o(irq), .receive_message_irq_flag_o(rx_irq), .remote_frame_irq_flag_o(rem_irq),
    .transmit_wait_clear_o(twc));
  // ------------------------------------------------------------
  // apb master: hold request until pready seen high
  // ------------------------------------------------------------
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge sys_clk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    n = 0;
    // bounded wait, slave latency is not assumed
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    logic [31:0] r;
    logic x;
    apb_xfer(1'b1, a, {16'h0000, v}, r, x);
  endtask
  // read compare, error flag folded in above the data
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] v);
    logic [31:0] r;
    logic x;
    apb_xfer(1'b0, a, 32'h0000_0000, r, x);
    `CHK($sformatf("read %0h", a), {17'h0_0000, v}, {x, r})
  endtask
  // mailbox number to register bit: low eight sit in the upper byte
  function automatic logic [15:0] mb(input int n);
    mb = (n < 8) ? (16'h0001 << (n + 8)) : (16'h0001 << (n - 8));
  endfunction
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // watchdog far beyond the few hundred cycles needed
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    mask = 16'h0000;
    req = '0;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd_chk(`CMSF_OFS_ABORT, 16'h0000);
    rd_chk(`CMSF_OFS_RX, 16'h0000);
    rd_chk(`CMSF_OFS_REMOTE, 16'h0000);
    apb_xfer(1'b0, 12'h018, 32'h0000_0000, d, e);
    `CHK("unmapped", 33'h1_0000_0000, {e, d})
    // abort on every mailbox: mailbox 0 has no flag, bit 8 stays 0
    eng.fire(16'hFFFF, 16'h0000, 16'h0000, 16'h0000);
    rd_chk(`CMSF_OFS_ABORT, 16'hFEFF);
    wr(`CMSF_OFS_ABORT, 16'h8000);
    rd_chk(`CMSF_OFS_ABORT, 16'h7EFF);
    wr(`CMSF_OFS_ABORT, 16'h0000);
    rd_chk(`CMSF_OFS_ABORT, 16'h7EFF);
    wr(`CMSF_OFS_ABORT, 16'hFEFF);
    rd_chk(`CMSF_OFS_ABORT, 16'h0000);
    // transmit wait clear on send and on cancel
    eng.fire(16'h0000, 16'h0020, 16'h0000, 16'h0000);
    #1 `CHK("twc send", 16'h0020, twc)
    eng.fire(16'h0200, 16'h0000, 16'h0000, 16'h0000);
    #1 `CHK("twc cancel", 16'h0200, twc)
    wr(`CMSF_OFS_ABORT, mb(9));
    // remote frame into each mailbox in turn
    for (int n = 0; n < 16; n++) begin
      eng.fire(16'h0000, 16'h0000, 16'h0001 << n, 16'h0001 << n);
      rd_chk(`CMSF_OFS_RX, mb(n));
      rd_chk(`CMSF_OFS_REMOTE, mb(n));
      wr(`CMSF_OFS_REMOTE, mb(n));
      rd_chk(`CMSF_OFS_RX, mb(n));
      wr(`CMSF_OFS_RX, mb(n));
      rd_chk(`CMSF_OFS_REMOTE, 16'h0000);
    end
    // data frame with junk qualifier on other mailboxes
    eng.fire(16'h0000, 16'h0000, 16'h0008, 16'hFFF7);
    #1 `CHK("rx irq", 1'b1, rx_irq)
    `CHK("rem irq", 1'b0, rem_irq)
    rd_chk(`CMSF_OFS_RX, mb(3));
    rd_chk(`CMSF_OFS_REMOTE, 16'h0000);
    wr(`CMSF_OFS_RX, mb(3));
    `CHK("rx irq clr", 1'b0, rx_irq)
    // masked mailbox raises no irq flag
    @(posedge sys_clk_i);
    mask <= 16'h0010;
    eng.fire(16'h0000, 16'h0000, 16'h0010, 16'h0010);
    #1 `CHK("rx irq msk", 1'b0, rx_irq)
    `CHK("rem irq msk", 1'b0, rem_irq)
    wr(`CMSF_OFS_REMOTE, mb(4));
    wr(`CMSF_OFS_RX, mb(4));
    @(posedge sys_clk_i);
    mask <= 16'h0000;
    eng.fire(16'h0000, 16'h0000, 16'h0400, 16'h0400);
    #1 `CHK("rem irq", 1'b1, rem_irq)
    wr(`CMSF_OFS_REMOTE, mb(10));
    `CHK("rem irq clr", 1'b0, rem_irq)
    `CHK("rx irq hold", 1'b1, rx_irq)
    wr(`CMSF_OFS_RX, mb(10));
    `CHK("rx irq off", 1'b0, rx_irq)
    // interrupt status, enable and clear
    rd_chk(`CMSF_OFS_IRQ_STAT, 16'h0007);
    `CHK("irq off", 1'b0, irq)
    wr(`CMSF_OFS_IRQ_EN, 16'h0002);
    rd_chk(`CMSF_OFS_IRQ_EN, 16'h0002);
    `CHK("irq on", 1'b1, irq)
    wr(`CMSF_OFS_IRQ_STAT, 16'h0007);
    wr(`CMSF_OFS_IRQ_CLR, 16'h0002);
    `CHK("irq clr", 1'b0, irq)
    rd_chk(`CMSF_OFS_IRQ_STAT, 16'h0005);
    // clock enable low: an event in that window is lost
    @(posedge sys_clk_i);
    ce <= 1'b0;
    eng.fire(16'h0000, 16'h0000, 16'h0020, 16'h0020);
    ce <= 1'b1;
    rd_chk(`CMSF_OFS_RX, 16'h0000);
    rd_chk(`CMSF_OFS_IRQ_STAT, 16'h0005);
    `CHK("ce irq", 1'b0, irq)
    // set and clear meet on the same edge: set wins
    eng.fire(16'h0000, 16'h0000, 16'h0040, 16'h0000);
    fork
      wr(`CMSF_OFS_RX, mb(6));
      begin
        @(posedge sys_clk_i);
        eng.fire(16'h0000, 16'h0000, 16'h0040, 16'h0000);
      end
    join
    rd_chk(`CMSF_OFS_RX, mb(6));
    wrap_up();
  end
endmodule // cmsf_top_tb
`default_nettype wire
